//--- common/aec_pkg.sv
// Purpose: shared constants and types of the gated event counter pair
// Assumes: 8-bit register port, 4-bit register index, one 200 MHz clock
// Notes:   all register offsets and field positions live here only
package aec_pkg;

	// ****************************************
	// register indices
	// ****************************************
	localparam logic [3:0] AEC_A_CSR  = 4'h0;
	localparam logic [3:0] AEC_A_CLK  = 4'h1;
	localparam logic [3:0] AEC_A_EGS  = 4'h2;
	localparam logic [3:0] AEC_A_CNTH = 4'h3;
	localparam logic [3:0] AEC_A_CNTL = 4'h4;
	localparam logic [3:0] AEC_A_IRQ  = 4'h5;
	localparam logic [3:0] AEC_A_CMPL = 4'h6;
	localparam logic [3:0] AEC_A_CMPH = 4'h7;
	localparam logic [3:0] AEC_A_DATL = 4'h8;
	localparam logic [3:0] AEC_A_DATH = 4'h9;

	// ****************************************
	// field positions
	// ****************************************
	localparam int B_OVH   = 7;
	localparam int B_OVL   = 6;
	localparam int B_SPLIT = 4;
	localparam int B_HEN   = 3;
	localparam int B_LEN   = 2;
	localparam int B_HREL  = 1;
	localparam int B_LREL  = 0;
	localparam int F_HSRC  = 6;
	localparam int F_HEDG  = 4;
	localparam int F_LSRC  = 2;
	localparam int F_LEDG  = 0;
	localparam int F_PSEL  = 4;
	localparam int F_GEDG  = 2;
	localparam int B_PWMEN = 0;
	localparam int B_OVF_F = 0;
	localparam int B_GAT_F = 1;
	localparam int B_OVF_E = 4;
	localparam int B_GAT_E = 5;

	// ****************************************
	// encodings, widths and reset values
	// ****************************************
	localparam logic [1:0] SRC_PIN  = 2'h0;
	localparam logic [1:0] SRC_DIV2 = 2'h1;
	localparam logic [1:0] SRC_DIV4 = 2'h2;
	localparam logic [1:0] EDG_FALL = 2'h0;
	localparam logic [1:0] EDG_RISE = 2'h1;
	localparam int         PRE_W    = 6;
	localparam logic [7:0] CSR_WMSK = 8'h1f;
	localparam logic [7:0] BYTE_0   = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [15:0] WORD_0  = 16'h0000;

	typedef enum logic [2:0] {
		PM_ACTIVE, PM_SLEEP, PM_WATCH, PM_SUBACT, PM_SUBSLP, PM_STBY, PM_MSTBY
	} aec_pmode_e;

endpackage

//--- design/aec_pwm.sv
// Purpose: internal PWM gate generator for the event counter pair
// Assumes: cmp above dat while enabled; tick is a one-cycle enable
// Notes:   output low for dat+1 ticks, high for cmp-dat ticks
`timescale 1ns/1ps
module aec_pwm
	import aec_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        en,
	input  wire logic        tick,
	input  wire logic [15:0] cmp,
	input  wire logic [15:0] dat,
	output logic             pwm_out
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        out;
	} aec_pwm_s;

	aec_pwm_s s;
	aec_pwm_s n;

	// ****************************************
	// period counter
	// ****************************************
	// disabling parks the output low; the top then gates the counters from gate_pin instead
	always_comb begin
		n = s;
		if (!en) begin
			n.cnt = WORD_0;
			n.out = 1'b0;
		end else if (tick) begin
			n.cnt = (s.cnt == cmp) ? WORD_0 : s.cnt + 16'h0001;
			n.out = (n.cnt > dat);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pwm_out = s.out;

	// ****************************************
	// checks
	// ****************************************
	sequence pwm_wrap_sq;
		en && tick && (s.cnt == cmp);
	endsequence

	sequence pwm_rise_sq;
		en && tick && (s.cnt == dat) && (dat < cmp);
	endsequence

	a_pwm_wrap_low: assert property (@(posedge mclk) disable iff (!nrst)
		pwm_wrap_sq |=> (s.cnt == WORD_0) && !pwm_out)
		else $error("pwm did not restart low");

	a_pwm_goes_high: assert property (@(posedge mclk) disable iff (!nrst)
		pwm_rise_sq |=> pwm_out)
		else $error("pwm did not go high after low phase");

endmodule

//--- design/aec_top.sv
// Purpose: pair of 8-bit event counters with common gate and PWM gate
// Assumes: all inputs synchronous to mclk; register read data one cycle late
// Notes:   cascades to 16 bits unless split mode is set
// Function
// - split mode: two independent 8-bit counters
// - high source: div2, div4, div8 or pin
// - low source: div2, div4, div8 or pin
// - pin edge chosen by per-pin edge field
// - high FF wraps to 00, sets flag
// - low FF wraps to 00, sets flag in split mode
// - any overflow sets flag, enabled raises irq
// - gate pin low stops both counters
// - pwm output low stops both counters
// - gate pin edge sets gate irq flag
// - pwm edge sets same gate irq flag
// - gate edge: rising, falling or both
// - gating may lose at most one count
// - watch/standby: pin counting, no overflow flags
// - low power: only pin-sourced counters count
// - module standby halts all, gate ignored
// - watch/standby: gating works, no gate irq
// - gate irq flag sets in the same cycle as the halt
// - cascade mode: low overflow clocks high
// - count enable low holds counter value
// - reset release low holds counter zero
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module aec_top
	import aec_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic        high_event_pin,
	input  wire logic        low_event_pin,
	input  wire logic        gate_pin,
	input  aec_pmode_e       pwr_mode,
	output logic             ovf_irq_req,
	output logic             gate_irq_req
);

	// ****************************************
	// helper functions
	// ****************************************
	// true once every 2^min(k, PRE_W) cycles of the free prescaler
	function automatic logic div_tick(input logic [PRE_W-1:0] pre, input int k);
		logic [PRE_W-1:0] mask;
		mask = PRE_W'((1 << k) - 1);
		return (pre & mask) == mask;
	endfunction

	function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
		logic hit;
		case (sel)
			EDG_FALL: hit = prev & ~cur;
			EDG_RISE: hit = ~prev & cur;
			default:  hit = prev ^ cur;
		endcase
		return hit;
	endfunction

	function automatic logic src_tick(input logic [1:0] sel, input logic [PRE_W-1:0] pre,
			input logic pin);
		logic t;
		case (sel)
			SRC_PIN:  t = pin;
			SRC_DIV2: t = div_tick(pre, 1);
			SRC_DIV4: t = div_tick(pre, 2);
			default:  t = div_tick(pre, 3);
		endcase
		return t;
	endfunction

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]       csr;
		logic [7:0]       clk;
		logic [7:0]       egs;
		logic [7:0]       irq;
		logic [15:0]      cmp;
		logic [15:0]      dat;
		logic [7:0]       cnt_h;
		logic [7:0]       cnt_l;
		logic [PRE_W-1:0] pre;
		logic             hpin_q;
		logic             lpin_q;
		logic             gate_q;
		logic [7:0]       rdata;
		logic             ovf_irq;
		logic             gate_irq;
	} aec_st_s;

	aec_st_s s;
	aec_st_s n;

	logic       pwm_out;
	logic       pm_lp;
	logic       pm_nof;
	logic       pm_ms;
	logic       pm_fast;
	logic       split;
	logic       pwm_en;
	logic       gate_lvl;
	logic       gate_hit;
	logic       gate_set;
	logic       l_tick;
	logic       l_ok;
	logic       l_inc;
	logic       l_ovf;
	logic       h_tick;
	logic       h_ok;
	logic       h_inc;
	logic       h_ovf;
	logic       ovh_set;
	logic       ovl_set;
	logic       pwm_tick;
	logic       csr_wr;
	logic       irq_wr;
	logic [1:0] hsrc;
	logic [1:0] lsrc;

	// ****************************************
	// power mode decode
	// ****************************************
	assign pm_ms   = (pwr_mode == PM_MSTBY);
	assign pm_nof  = (pwr_mode == PM_WATCH) || (pwr_mode == PM_STBY);
	assign pm_lp   = pm_nof || (pwr_mode == PM_SUBACT) || (pwr_mode == PM_SUBSLP);
	assign pm_fast = (pwr_mode == PM_ACTIVE) || (pwr_mode == PM_SLEEP);

	// ****************************************
	// gate selection and gate interrupt edge
	// ****************************************
	assign split    = s.csr[B_SPLIT];
	assign pwm_en   = s.egs[B_PWMEN];
	assign gate_lvl = pwm_en ? pwm_out : gate_pin;
	// edge seen against last cycle's level, so flag sets on the same edge the halt takes effect
	assign gate_hit = edge_hit(s.gate_q, gate_lvl, s.egs[F_GEDG +: 2]);
	assign gate_set = gate_hit && !pm_nof && !pm_ms;

	// ****************************************
	// counter clocking
	// ****************************************
	assign hsrc = s.clk[F_HSRC +: 2];
	assign lsrc = s.clk[F_LSRC +: 2];
	// slow modes stop the divided system clock; pin sources keep running
	assign l_ok = !pm_ms && (!pm_lp || lsrc == SRC_PIN);
	assign h_ok = !pm_ms && (!pm_lp || hsrc == SRC_PIN);
	assign l_tick = src_tick(lsrc, s.pre, edge_hit(s.lpin_q, low_event_pin,
		s.clk[F_LEDG +: 2]));
	// gate is sampled level-wise, so a tick near its edge may be lost
	assign l_inc = s.csr[B_LREL] && s.csr[B_LEN] && gate_lvl && l_tick && l_ok;
	assign l_ovf = l_inc && (s.cnt_l == BYTE_MAX);
	assign h_tick = split ? (src_tick(hsrc, s.pre, edge_hit(s.hpin_q, high_event_pin,
		s.clk[F_HEDG +: 2])) && gate_lvl && h_ok) : l_ovf;
	assign h_inc = s.csr[B_HREL] && s.csr[B_HEN] && h_tick;
	assign h_ovf = h_inc && (s.cnt_h == BYTE_MAX);
	assign ovh_set = h_ovf && !pm_nof;
	assign ovl_set = l_ovf && split && !pm_nof;
	assign pwm_tick = div_tick(s.pre, int'(s.egs[F_PSEL +: 3]) + 1);
	assign csr_wr = wr && (addr == AEC_A_CSR);
	assign irq_wr = wr && (addr == AEC_A_IRQ);

	// ****************************************
	// register port and next state
	// ****************************************
	// flags clear on a written 0; a hardware set in the same cycle wins
	always_comb begin
		n = s;
		n.rdata = BYTE_0;
		if (rd) begin
			case (addr)
				AEC_A_CSR:  n.rdata = s.csr;
				AEC_A_CLK:  n.rdata = s.clk;
				AEC_A_EGS:  n.rdata = s.egs;
				AEC_A_CNTH: n.rdata = s.cnt_h;
				AEC_A_CNTL: n.rdata = s.cnt_l;
				AEC_A_IRQ:  n.rdata = s.irq;
				AEC_A_CMPL: n.rdata = s.cmp[7:0];
				AEC_A_CMPH: n.rdata = s.cmp[15:8];
				AEC_A_DATL: n.rdata = s.dat[7:0];
				AEC_A_DATH: n.rdata = s.dat[15:8];
				default:    n.rdata = BYTE_0;
			endcase
		end
		if (wr) begin
			case (addr)
				AEC_A_CSR: begin
					n.csr = (wdata & CSR_WMSK) | (s.csr & wdata & ~CSR_WMSK);
				end
				AEC_A_CLK:  n.clk = wdata;
				AEC_A_EGS:  n.egs = wdata;
				AEC_A_IRQ: begin
					n.irq = wdata;
					n.irq[B_OVF_F] = s.irq[B_OVF_F] & wdata[B_OVF_F];
					n.irq[B_GAT_F] = s.irq[B_GAT_F] & wdata[B_GAT_F];
				end
				AEC_A_CMPL: n.cmp[7:0] = wdata;
				AEC_A_CMPH: n.cmp[15:8] = wdata;
				AEC_A_DATL: n.dat[7:0] = wdata;
				AEC_A_DATH: n.dat[15:8] = wdata;
				default: ;
			endcase
		end
		// counters: wrap from FF to 00 falls out of the 8-bit add
		if (!s.csr[B_LREL]) begin
			n.cnt_l = BYTE_0;
		end else if (l_inc) begin
			n.cnt_l = s.cnt_l + 8'h01;
		end
		if (!s.csr[B_HREL]) begin
			n.cnt_h = BYTE_0;
		end else if (h_inc) begin
			n.cnt_h = s.cnt_h + 8'h01;
		end
		if (ovh_set) begin
			n.csr[B_OVH] = 1'b1;
		end
		if (ovl_set) begin
			n.csr[B_OVL] = 1'b1;
		end
		if (ovh_set || ovl_set) begin
			n.irq[B_OVF_F] = 1'b1;
		end
		if (gate_set) begin
			n.irq[B_GAT_F] = 1'b1;
		end
		// module standby freezes every edge history with the clock
		if (!pm_ms) begin
			n.pre    = s.pre + 6'h01;
			n.hpin_q = high_event_pin;
			n.lpin_q = low_event_pin;
			n.gate_q = gate_lvl;
		end
		n.ovf_irq  = n.irq[B_OVF_F] && n.irq[B_OVF_E];
		n.gate_irq = n.irq[B_GAT_F] && n.irq[B_GAT_E];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// pwm gate generator
	// ****************************************
	// pwm halts outside the fast modes but keeps its phase and level
	aec_pwm u_pwm (
		.mclk    (mclk),
		.nrst    (nrst),
		.en      (pwm_en),
		.tick    (pwm_tick && pm_fast),
		.cmp     (s.cmp),
		.dat     (s.dat),
		.pwm_out (pwm_out)
	);

	assign rdata        = s.rdata;
	assign ovf_irq_req  = s.ovf_irq;
	assign gate_irq_req = s.gate_irq;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence cnt_quiet_sq;
		s.csr[B_LREL] && s.csr[B_HREL] && !csr_wr;
	endsequence

	a_low_held_zero: assert property (!s.csr[B_LREL] && !csr_wr |=> s.cnt_l == BYTE_0)
		else $error("low counter not held at zero");

	a_low_wrap: assert property (l_inc && s.cnt_l == BYTE_MAX |=> s.cnt_l == BYTE_0)
		else $error("low counter did not wrap");

	a_high_cascade: assert property (!split && l_ovf && s.csr[B_HREL] && s.csr[B_HEN]
		|=> s.cnt_h == $past(s.cnt_h) + 8'h01)
		else $error("cascade did not clock high counter");

	a_gate_stops: assert property (cnt_quiet_sq and !gate_lvl
		|=> $stable(s.cnt_l) && $stable(s.cnt_h))
		else $error("counter moved while gate low");

	a_low_ovf_flag: assert property (ovl_set |=> s.csr[B_OVL] ##1 s.csr[B_OVL] || $past(csr_wr))
		else $error("low overflow flag not set");

	a_ovf_irq_out: assert property (ovh_set && s.irq[B_OVF_E] && !irq_wr
		|=> s.irq[B_OVF_F] && ovf_irq_req)
		else $error("overflow irq not raised");

	a_gate_irq_flag: assert property (gate_set && !irq_wr |=> s.irq[B_GAT_F])
		else $error("gate irq flag not set");

	a_watch_no_ovf: assert property (pm_nof |=> !$rose(s.csr[B_OVH]) && !$rose(s.csr[B_OVL]))
		else $error("overflow flag set in watch or standby");

	a_mstby_halt: assert property (pm_ms and cnt_quiet_sq
		|=> $stable(s.cnt_l) && $stable(s.cnt_h) && !$rose(s.irq[B_GAT_F]))
		else $error("activity in module standby");

	a_lp_sys_halt: assert property (pm_lp && lsrc != SRC_PIN && s.csr[B_LREL] && !csr_wr
		|=> $stable(s.cnt_l))
		else $error("low counter ran from system clock in low power");

	a_read_slot: assert property (rd && addr == AEC_A_CNTL && !csr_wr
		|=> rdata == $past(s.cnt_l))
		else $error("read data not presented one cycle later");

	a_high_wrap: assert property (h_inc && s.cnt_h == BYTE_MAX |=> s.cnt_h == BYTE_0)
		else $error("high counter did not wrap");

	a_high_ovf_flag: assert property (ovh_set |=> s.csr[B_OVH])
		else $error("high overflow flag not set");

	// enable low must freeze a released counter whatever its source does
	a_low_en_hold: assert property (s.csr[B_LREL] && !s.csr[B_LEN] |=> $stable(s.cnt_l))
		else $error("low counter moved while disabled");

	a_high_en_hold: assert property (s.csr[B_HREL] && !s.csr[B_HEN] |=> $stable(s.cnt_h))
		else $error("high counter moved while disabled");

	a_pwm_gate_stop: assert property (s.csr[B_LREL] && pwm_en && !pwm_out |=> $stable(s.cnt_l))
		else $error("low counter moved while pwm gate low");

	a_gate_irq_out: assert property (gate_set && s.irq[B_GAT_E] && !irq_wr |=> gate_irq_req)
		else $error("gate irq not raised");

	a_lp_no_gate_irq: assert property (pm_nof |=> !$rose(s.irq[B_GAT_F]))
		else $error("gate irq flag set in watch or standby");

endmodule

//--- testbench/aec_evt_model.sv
// Purpose: event pin source standing at the far side of the counter pair
// Assumes: pins idle low between bursts; go is a one-cycle request
// Notes:   each pulse gives one rising and one falling edge
`timescale 1ns/1ps
module aec_evt_model (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [1:0] sel,
	input  wire logic [8:0] n,
	input  wire logic       slow,
	output logic            high_event_pin,
	output logic            low_event_pin,
	output logic            busy
);
	logic [9:0] left = '0;
	logic [1:0] div  = '0;
	logic       lvl  = 1'b0;

	// ****************************************
	// burst generator
	// ****************************************
	// half period of one or four cycles, so slow sources are met too
	always @(posedge mclk) begin
		if (go) begin
			left <= {n, 1'b0};
			div <= '0;
		end else if (left != '0) begin
			div <= div + 2'h1;
			if (!slow || div == 2'h3) begin
				lvl <= ~lvl;
				left <= left - 10'h1;
			end
		end
	end

	// unselected pin stays at its idle low level
	assign busy           = go || (left != '0);
	assign high_event_pin = lvl & sel[1];
	assign low_event_pin  = lvl & sel[0];
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench for the gated event counter pair
// Assumes: read data one cycle after the read strobe
// Notes:   reads queue their expectation; a monitor compares
`timescale 1ns/1ps
module testbench;
	import aec_pkg::*;
	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	logic [3:0] addr = '0;
	logic [7:0] wdata = '0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       rd_q = 1'b0;
	logic       gate_pin = 1'b1;
	logic       go = 1'b0;
	logic       slow = 1'b0;
	logic [1:0] sel = '0;
	logic [8:0] n = '0;
	logic [8:0] k;
	logic [7:0] rdata;
	logic       high_event_pin, low_event_pin, busy, ovf_irq_req, gate_irq_req;
	aec_pmode_e pwr_mode = PM_ACTIVE;
	int         bad_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         seed = 55;
	logic [7:0] exp_q[$];
	string      nm_q[$];

	aec_top aec_top_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .high_event_pin(high_event_pin), .low_event_pin(low_event_pin),
		.gate_pin(gate_pin), .pwr_mode(pwr_mode), .ovf_irq_req(ovf_irq_req),
		.gate_irq_req(gate_irq_req));
	aec_evt_model aec_evt_model_i (.mclk(mclk), .go(go), .sel(sel), .n(n), .slow(slow),
		.high_event_pin(high_event_pin), .low_event_pin(low_event_pin), .busy(busy));

	always #2.5 mclk = ~mclk;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// idle cycle after each strobe keeps a strobe from being set twice in one step
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(exp);
		nm_q.push_back(what);
		@(posedge mclk);
		rd <= 1'b0;
	endtask

	task automatic pulse(input logic [1:0] s, input logic [8:0] cnt, input logic sl);
		@(posedge mclk);
		sel <= s;
		n <= cnt;
		slow <= sl;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		while (busy) @(posedge mclk);
		repeat (3) @(posedge mclk);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		rd_q <= rd;
		if (rd_q)
			chk(rdata, exp_q.pop_front(), nm_q.pop_front());
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		for (int a = 0; a < 11; a++)
			rreg(4'(a), 8'h00, "reset or unmapped read");
		chk({7'h0, ovf_irq_req}, 8'h00, "ovf irq after reset");
		$display("test reset done");

		// split mode, high pin rising, low pin falling, slow bursts
		wreg(AEC_A_CLK, 8'h10);
		wreg(AEC_A_CSR, 8'h1f);
		k = 9'(1 + ($random(seed) & 7));
		pulse(2'h3, k, 1'b1);
		wreg(AEC_A_CSR, 8'h13);
		rreg(AEC_A_CNTH, k[7:0], "high count");
		rreg(AEC_A_CNTL, k[7:0], "low count");
		pulse(2'h3, 9'h2, 1'b0);
		rreg(AEC_A_CNTL, k[7:0], "low held disabled");
		wreg(AEC_A_CSR, 8'h1f);
		gate_pin <= 1'b0;
		pulse(2'h3, 9'h4, 1'b0);
		gate_pin <= 1'b1;
		wreg(AEC_A_CSR, 8'h13);
		rreg(AEC_A_CNTH, k[7:0], "high gated off");
		rreg(AEC_A_CNTL, k[7:0], "low gated off");
		$display("test split done");

		// high counter runs through FF while the low one stays put
		wreg(AEC_A_IRQ, 8'h10);
		wreg(AEC_A_CSR, 8'h1f);
		pulse(2'h2, 9'h100 - k, 1'b0);
		chk({7'h0, ovf_irq_req}, 8'h01, "ovf irq level");
		wreg(AEC_A_CSR, 8'h93);
		rreg(AEC_A_CSR, 8'h93, "high ovf flag");
		rreg(AEC_A_CNTH, 8'h00, "high wrapped");
		rreg(AEC_A_CNTL, k[7:0], "low independent");
		rreg(AEC_A_IRQ, 8'h11, "ovf irq flag");
		wreg(AEC_A_IRQ, 8'h10);
		repeat (2) @(posedge mclk);
		chk({7'h0, ovf_irq_req}, 8'h00, "ovf irq cleared");
		// low counter runs through FF while the high one stays at zero
		wreg(AEC_A_CSR, 8'h1f);
		pulse(2'h1, 9'h100 - k, 1'b0);
		chk({7'h0, ovf_irq_req}, 8'h01, "low ovf irq level");
		wreg(AEC_A_CSR, 8'h53);
		rreg(AEC_A_CSR, 8'h53, "low ovf flag");
		rreg(AEC_A_CNTL, 8'h00, "low wrapped");
		rreg(AEC_A_CNTH, 8'h00, "high independent");
		$display("test overflow done");

		// cascade: low wrap clocks the high counter
		wreg(AEC_A_CSR, 8'h00);
		rreg(AEC_A_CNTL, 8'h00, "held at zero");
		wreg(AEC_A_CSR, 8'h0f);
		pulse(2'h1, 9'h101, 1'b0);
		wreg(AEC_A_CSR, 8'h0b);
		rreg(AEC_A_CNTL, 8'h01, "cascade low");
		rreg(AEC_A_CNTH, 8'h01, "cascade high");
		$display("test cascade done");

		// gate edge sense: falling, rising, both
		for (int e = 0; e < 3; e++) begin
			wreg(AEC_A_EGS, 8'(e << 2));
			wreg(AEC_A_IRQ, 8'h20);
			gate_pin <= 1'b0;
			repeat (3) @(posedge mclk);
			chk({7'h0, gate_irq_req}, 8'(e != 1), "gate irq fall");
			wreg(AEC_A_IRQ, 8'h20);
			gate_pin <= 1'b1;
			repeat (3) @(posedge mclk);
			chk({7'h0, gate_irq_req}, 8'(e != 0), "gate irq rise");
		end
		rreg(AEC_A_IRQ, 8'h22, "gate irq flag");
		$display("test gate irq done");

		// divided sources: eight enabled cycles give 1 tick at /8 and 4 at /2
		wreg(AEC_A_CSR, 8'h00);
		wreg(AEC_A_CLK, 8'hc4);
		wreg(AEC_A_CSR, 8'h1f);
		repeat (6) @(posedge mclk);
		wreg(AEC_A_CSR, 8'h13);
		rreg(AEC_A_CNTH, 8'h01, "high div8 count");
		rreg(AEC_A_CNTL, 8'h04, "low div2 count");
		wreg(AEC_A_CLK, 8'h10);
		$display("test divided source done");

		// pwm gate: low for 256 ticks of two cycles, then high for 256 ticks
		wreg(AEC_A_CSR, 8'h00);
		wreg(AEC_A_CMPL, 8'hff);
		wreg(AEC_A_CMPH, 8'h01);
		wreg(AEC_A_DATL, 8'hff);
		wreg(AEC_A_DATH, 8'h00);
		wreg(AEC_A_CSR, 8'h1f);
		wreg(AEC_A_EGS, 8'h05);
		wreg(AEC_A_IRQ, 8'h20);
		pulse(2'h3, 9'h5, 1'b0);
		chk({7'h0, gate_irq_req}, 8'h00, "pwm still low");
		repeat (600) @(posedge mclk);
		chk({7'h0, gate_irq_req}, 8'h01, "pwm rise irq");
		pulse(2'h3, 9'h6, 1'b0);
		wreg(AEC_A_EGS, 8'h04);
		wreg(AEC_A_CSR, 8'h13);
		rreg(AEC_A_CNTH, 8'h06, "high pwm gated");
		rreg(AEC_A_CNTL, 8'h06, "low pwm gated");
		$display("test pwm gate done");

		// module standby halts pin counting, watch keeps it
		wreg(AEC_A_CSR, 8'h00);
		wreg(AEC_A_CSR, 8'h1f);
		pwr_mode <= PM_MSTBY;
		pulse(2'h3, 9'h3, 1'b0);
		pwr_mode <= PM_ACTIVE;
		rreg(AEC_A_CNTL, 8'h00, "module standby halt");
		pwr_mode <= PM_WATCH;
		pulse(2'h3, 9'h3, 1'b0);
		pwr_mode <= PM_ACTIVE;
		wreg(AEC_A_CSR, 8'h13);
		rreg(AEC_A_CNTH, 8'h03, "watch pin count");
		$display("test power modes done");
		repeat (2) @(posedge mclk);
		close_out();
	end
endmodule
